// file: hw/cso_clock_stop.sv
// Clock output stop control: gates CPU, SRC, free PCI and PCI outputs
`timescale 1ns/1ps
`include "cso_defs.svh"

module cso_clock_stop (
    input  wire logic                   clk_i,
    input  wire logic                   srst_i,
    input  wire logic                   cpu_stop_n_i,      // CPU stop pin
    input  wire logic                   pci_link_stop_n_i, // PCI/SRC stop pin
    input  wire cso_pkg::cso_stop_cfg_t cfg_i,             // Stoppable bits
    output cso_pkg::cso_clk_out_t       clocks_o           // Gated clocks
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    logic                      cpu_ph_reg;   // Free CPU phase, true leg
    logic                      cpu_ph_next;
    logic [`CSO_PCI_CNT_W-1:0] pci_cnt_reg;  // Free PCI divider
    logic [`CSO_PCI_CNT_W-1:0] pci_cnt_next;
    cso_pkg::cso_clk_out_t     clocks_reg;   // Output flops
    cso_pkg::cso_clk_out_t     clocks_next;

    logic cpu_stopped;       // CPU gate, registered
    logic cpu_stopped_next;  // CPU gate, next value
    logic src_stopped;       // SRC gate, registered
    logic src_stopped_next;  // SRC gate, next value
    logic pci_stopped;       // PCI gate, registered
    logic pci_stopped_next;  // PCI gate, next value
    logic cpu_park;          // CPU true leg goes high next
    logic pci_park;          // PCI output goes low next

    // Park points come from the free phases, never from gated outputs
    assign cpu_park = ~cpu_ph_reg;
    assign pci_park = (pci_cnt_reg == `CSO_PCI_PARK_CNT);

    ////////////////////////////////////////////////////////////////////
    // Stop gates: CPU pin, and the link pin twice, once per domain

    // CPU outputs sample the CPU stop pin on the CPU phase
    cso_stop_sync #(
        .PARK_WAIT (`CSO_CPU_PARK_WAIT)
    ) u_cpu_gate (
        .clk_i          (clk_i),
        .srst_i         (srst_i),
        .stop_n_i       (cpu_stop_n_i),
        .park_i         (cpu_park),
        .stopped_next_o (cpu_stopped_next),
        .stopped_o      (cpu_stopped)
    );

    // SRC follows CPU sampling and parking, driven by the link pin
    cso_stop_sync #(
        .PARK_WAIT (`CSO_CPU_PARK_WAIT)
    ) u_src_gate (
        .clk_i          (clk_i),
        .srst_i         (srst_i),
        .stop_n_i       (pci_link_stop_n_i),
        .park_i         (cpu_park),
        .stopped_next_o (src_stopped_next),
        .stopped_o      (src_stopped)
    );

    // PCI and free PCI outputs park low on the PCI phase
    cso_stop_sync #(
        .PARK_WAIT (`CSO_PCI_PARK_WAIT)
    ) u_pci_gate (
        .clk_i          (clk_i),
        .srst_i         (srst_i),
        .stop_n_i       (pci_link_stop_n_i),
        .park_i         (pci_park),
        .stopped_next_o (pci_stopped_next),
        .stopped_o      (pci_stopped)
    );

    ////////////////////////////////////////////////////////////////////
    // Free-running phases: never gated, so the rest keeps running
    always_comb
    begin
        cpu_ph_next  = ~cpu_ph_reg;
        pci_cnt_next = pci_cnt_reg + `CSO_PCI_CNT_ONE;
    end

    // Phase registers
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cpu_ph_reg  <= 1'b0;
            pci_cnt_reg <= `CSO_PCI_CNT_RST;
        end
        else
        begin
            cpu_ph_reg  <= cpu_ph_next;
            pci_cnt_reg <= pci_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output gating. Settings come from same-clock control logic;
    // changing them while stopped may cut a pulse, so software
    // should only change them while the stop pins are high.
    always_comb
    begin
        // Stopped and stoppable: true held high, complement low
        clocks_next.cpu_clk_true = {`CSO_N_CPU{cpu_ph_next}}
            | (cfg_i.cpu_en & {`CSO_N_CPU{cpu_stopped_next}});
        clocks_next.cpu_clk_comp = ~clocks_next.cpu_clk_true;
        // SRC parks the same way, gated by its own bits
        clocks_next.link_ref_clk_true = {`CSO_N_SRC{cpu_ph_next}}
            | (cfg_i.src_en & {`CSO_N_SRC{src_stopped_next}});
        clocks_next.link_ref_clk_comp = ~clocks_next.link_ref_clk_true;
        // Free PCI outputs stop low only where selected
        clocks_next.pci_free_clk =
            {`CSO_N_PCI_FREE_CLK{pci_cnt_next[`CSO_PCI_CNT_MSB]}}
            & ~(cfg_i.pci_free_clk_en & {`CSO_N_PCI_FREE_CLK{pci_stopped_next}});
        // Plain PCI outputs always obey the link pin
        clocks_next.pci_clk =
            {`CSO_N_PCI{pci_cnt_next[`CSO_PCI_CNT_MSB]}}
            & ~{`CSO_N_PCI{pci_stopped_next}};
    end

    // Output flops; reset shows the CPU true legs low, PCI low
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            clocks_reg <= '0;
        end
        else
        begin
            clocks_reg <= clocks_next;
        end
    end

    assign clocks_o = clocks_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks, all on the system clock and idle in reset
    default clocking cb_sys @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    // Pin held low long enough to pass sync and park
    sequence s_cpu_pin_low;
        (!cpu_stop_n_i) [*8];
    endsequence

    // Pin held high long enough to pass sync and park
    sequence s_cpu_pin_high;
        cpu_stop_n_i [*8];
    endsequence

    // Link pin held high long enough
    sequence s_link_pin_high;
        pci_link_stop_n_i [*8];
    endsequence

    // Link pin held low long enough
    sequence s_link_pin_low;
        (!pci_link_stop_n_i) [*8];
    endsequence

    a_cpu_stop_pin: assert property (
        s_cpu_pin_low |-> cpu_stopped)
        else $error("CPU outputs not stopped after pin low");

    a_cpu_park_lvl: assert property (
        cpu_stopped |->
        ((clocks_reg.cpu_clk_true & $past(cfg_i.cpu_en))
            == $past(cfg_i.cpu_en))
        && ((clocks_reg.cpu_clk_comp & $past(cfg_i.cpu_en)) == '0))
        else $error("stopped CPU output not parked high/low");

    a_cpu_free_run: assert property (
        (!$past(cfg_i.cpu_en[0]) && !$past(cfg_i.cpu_en[0], 2)
            && !$past(srst_i))
        |-> (clocks_reg.cpu_clk_true[0]
            != $past(clocks_reg.cpu_clk_true[0])))
        else $error("non-stoppable CPU output stopped toggling");

    a_cpu_resume_pin: assert property (
        s_cpu_pin_high |-> !cpu_stopped)
        else $error("CPU outputs not resumed after pin high");

    a_cpu_low_pulse: assert property (
        $fell(clocks_reg.cpu_clk_true[0])
        |=> $rose(clocks_reg.cpu_clk_true[0]))
        else $error("CPU low phase stretched");

    a_pci_high_pulse: assert property (
        $rose(clocks_reg.pci_clk[0]) |=> clocks_reg.pci_clk[0])
        else $error("PCI high phase shortened");

    a_pci_park_low: assert property (
        pci_stopped |-> (clocks_reg.pci_clk == '0))
        else $error("stopped PCI output not low");

    // PCI park points come every four cycles, so the gate may move
    // one edge after eight pin samples; checked at the next edge
    a_pci_stop_pin: assert property (
        s_link_pin_low |=> pci_stopped)
        else $error("PCI outputs not stopped after pin low");

    a_pci_free_clk_select: assert property (
        (pci_stopped && !$past(cfg_i.pci_free_clk_en[0]) && !$past(srst_i))
        |-> (clocks_reg.pci_free_clk[0]
            == pci_cnt_reg[`CSO_PCI_CNT_MSB]))
        else $error("non-stoppable free PCI output stopped");

    a_pci_free_clk_park_low: assert property (
        pci_stopped
        |-> ((clocks_reg.pci_free_clk & $past(cfg_i.pci_free_clk_en)) == '0))
        else $error("stoppable free PCI output not low");

    a_src_park_lvl: assert property (
        src_stopped |->
        ((clocks_reg.link_ref_clk_true & $past(cfg_i.src_en))
            == $past(cfg_i.src_en)))
        else $error("stopped SRC output not parked high");

    a_src_stop_pin: assert property (
        s_link_pin_low |-> src_stopped)
        else $error("SRC outputs not stopped after pin low");

    a_src_resume: assert property (
        s_link_pin_high |-> !src_stopped)
        else $error("SRC outputs not resumed after pin high");

    a_pci_resume: assert property (
        s_link_pin_high |=> !pci_stopped)
        else $error("PCI outputs not resumed after pin high");

endmodule // cso_clock_stop

// file: hw/cso_defs.svh
// Constants for the clock output stop control block
//
// Contract
// - Stoppable CPU outputs halt two to six periods
// - Stopped CPU output parks true high, complement low
// - CPU stop leaves every other clock running
// - Per-output setting decides CPU stop response
// - No short or stretched pulse on resume
// - CPU outputs toggle within two cycles after release
// - Link stop pin stops and restarts PCI outputs
// - Free PCI and SRC obey own select bit
// - Stoppable SRC outputs behave like CPU outputs
// - PCI outputs resume within two PCI periods
// - Link stop release restarts SRC like CPU
`ifndef CSO_DEFS_SVH
`define CSO_DEFS_SVH

// Output counts per group
`define CSO_N_CPU        2
`define CSO_N_SRC        4
`define CSO_N_PCI_FREE_CLK       2
`define CSO_N_PCI        4

// Synchroniser depth and its idle value (pins deasserted high)
`define CSO_SYNC_W       3
`define CSO_SYNC_RST     3'h7

// Timing of the modelled clocks, in ns and in system clock cycles
`define CSO_SYS_PERIOD_NS   10
`define CSO_CPU_PERIOD_NS   20
`define CSO_CPU_PERIOD_CYC  (`CSO_CPU_PERIOD_NS / `CSO_SYS_PERIOD_NS)
`define CSO_PCI_PERIOD_NS   40
`define CSO_PCI_PERIOD_CYC  (`CSO_PCI_PERIOD_NS / `CSO_SYS_PERIOD_NS)

// PCI divider: two-bit count, output is its top bit
`define CSO_PCI_CNT_W    2
`define CSO_PCI_CNT_MSB  1
`define CSO_PCI_CNT_ONE  2'h1
`define CSO_PCI_CNT_RST  2'h0
`define CSO_PCI_PARK_CNT 2'h3

// Longest wait for a park point, in system clock cycles
`define CSO_CPU_PARK_WAIT 2
`define CSO_PCI_PARK_WAIT 4

`endif

// file: hw/cso_pkg.sv
// Types shared by the clock output stop control block
`include "cso_defs.svh"

package cso_pkg;

    // Stoppable settings, one bit per CPU, SRC and free PCI output, 1 = stoppable
    typedef struct packed {
        logic [`CSO_N_CPU-1:0]  cpu_en;
        logic [`CSO_N_SRC-1:0]  src_en;
        logic [`CSO_N_PCI_FREE_CLK-1:0] pci_free_clk_en;
    } cso_stop_cfg_t;

    // All gated clock outputs
    typedef struct packed {
        logic [`CSO_N_CPU-1:0]  cpu_clk_true;
        logic [`CSO_N_CPU-1:0]  cpu_clk_comp;
        logic [`CSO_N_SRC-1:0]  link_ref_clk_true;
        logic [`CSO_N_SRC-1:0]  link_ref_clk_comp;
        logic [`CSO_N_PCI_FREE_CLK-1:0] pci_free_clk;
        logic [`CSO_N_PCI-1:0]  pci_clk;
    } cso_clk_out_t;

endpackage

// file: hw/cso_stop_sync.sv
// Stop pin synchroniser and park-aligned gate
`timescale 1ns/1ps
`include "cso_defs.svh"

module cso_stop_sync #(
    parameter int PARK_WAIT = 2
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic stop_n_i,       // Asynchronous stop pin, low = stop
    input  wire logic park_i,         // Next output value is the park level
    output logic      stopped_next_o, // Gate value for the coming cycle
    output logic      stopped_o       // Registered gate
);

    logic [`CSO_SYNC_W-1:0] sync_reg;      // Pin synchroniser chain
    logic [`CSO_SYNC_W-1:0] sync_next;
    logic                   stop_lvl_reg;  // Agreed stop request
    logic                   stop_lvl_next;
    logic                   stopped_reg;   // Gate, moves only at park
    logic                   stopped_next;

    ////////////////////////////////////////////////////////////////////
    // Next state: stage 0 only feeds stage 1
    always_comb
    begin
        sync_next     = {sync_reg[`CSO_SYNC_W-2:0], stop_n_i};
        stop_lvl_next = stop_lvl_reg;
        stopped_next  = stopped_reg;
        // Accept a level once stages 1 and 2 agree
        if (sync_reg[`CSO_SYNC_W-2] == sync_reg[`CSO_SYNC_W-1])
        begin
            stop_lvl_next = ~sync_reg[`CSO_SYNC_W-1];
        end
        // Gate flips only when the output sits at park level,
        // so no pulse is ever cut or lengthened
        if (park_i)
        begin
            stopped_next = stop_lvl_reg;
        end
    end

    // Registers
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sync_reg     <= `CSO_SYNC_RST;
            stop_lvl_reg <= 1'b0;
            stopped_reg  <= 1'b0;
        end
        else
        begin
            sync_reg     <= sync_next;
            stop_lvl_reg <= stop_lvl_next;
            stopped_reg  <= stopped_next;
        end
    end

    assign stopped_next_o = stopped_next;
    assign stopped_o      = stopped_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks, all on the system clock and idle in reset
    default clocking cb_sync @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    a_lvl_needs_agree: assert property (
        $changed(stop_lvl_reg)
        |-> $past(sync_reg[`CSO_SYNC_W-2] == sync_reg[`CSO_SYNC_W-1]))
        else $error("stop level moved without stage agreement");

    a_gate_at_park: assert property (
        $changed(stopped_reg) |-> $past(park_i))
        else $error("gate moved off the park point");

    // A short legal pin pulse may withdraw the level before the park
    // point; the gate then owes nothing
    a_stop_latency: assert property (
        (stop_lvl_reg && !stopped_reg)
        |-> ##[1:PARK_WAIT] (stopped_reg || !stop_lvl_reg))
        else $error("stop not applied in time");

    a_resume_latency: assert property (
        (!stop_lvl_reg && stopped_reg)
        |-> ##[1:PARK_WAIT] (!stopped_reg || stop_lvl_reg))
        else $error("resume not applied in time");

endmodule // cso_stop_sync

// file: sim/cso_pm_model.sv
// Power-management partner model driving both stop pins
`timescale 1ns/1ps

module cso_pm_model (
    input  wire logic       clk_i,
    input  wire logic       cpu_req_i,     // 1 = ask for CPU stop
    input  wire logic       link_req_i,    // 1 = ask for PCI/SRC stop
    input  wire logic [1:0] lag_i,         // Extra edges before acting
    output logic            cpu_stop_n_o,  // CPU stop pin, low = stop
    output logic            link_stop_n_o  // PCI/SRC stop pin, low = stop
);
    logic [1:0] cnt_reg;                   // Lag counter

    initial
    begin
        cpu_stop_n_o  = 1'b1;
        link_stop_n_o = 1'b1;
        cnt_reg       = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////
    // Pins move on falling edges only, away from the sampling edge;
    // a lag lets the chipset answer slowly as well as promptly
    always @(negedge clk_i)
    begin
        if ({cpu_stop_n_o, link_stop_n_o} == {~cpu_req_i, ~link_req_i})
            cnt_reg <= 2'h0;
        else if (cnt_reg >= lag_i)
        begin
            cpu_stop_n_o  <= ~cpu_req_i;
            link_stop_n_o <= ~link_req_i;
            cnt_reg       <= 2'h0;
        end
        else
            cnt_reg <= cnt_reg + 2'h1;
    end
endmodule // cso_pm_model

// file: sim/tb_top.sv
// Self-checking testbench for the clock output stop control block
`timescale 1ns/1ps

module tb_top;
    typedef struct packed {
        cso_pkg::cso_clk_out_t chg;   // Bits that must toggle
        cso_pkg::cso_clk_out_t mask;  // Bits that must be parked
        cso_pkg::cso_clk_out_t park;  // Parked levels
    } cso_note_t;

    logic                  clk_i    = 1'b0;
    logic                  srst_i   = 1'b1;
    logic                  cpu_req  = 1'b0;  // Stop requests to partner
    logic                  link_req = 1'b0;
    logic [1:0]            lag      = 2'h0;
    cso_pkg::cso_stop_cfg_t cfg     = '0;
    cso_pkg::cso_clk_out_t clocks_o;
    logic                  cpu_stop_n;
    logic                  link_stop_n;
    int                    bad_count = 0;
    int                    n_checks  = 0;
    int                    seed      = 60;
    int                    hi_cnt    = 0;    // High run of one PCI clock
    bit                    seen_fall = 0;
    cso_note_t             q[$];             // Expected results, oldest first
    event                  go;

    always #5 clk_i = ~clk_i;

    cso_pm_model cso_pm_model_inst (
        .clk_i         (clk_i),
        .cpu_req_i     (cpu_req),
        .link_req_i    (link_req),
        .lag_i         (lag),
        .cpu_stop_n_o  (cpu_stop_n),
        .link_stop_n_o (link_stop_n)
    );

    cso_clock_stop cso_clock_stop_inst (
        .clk_i             (clk_i),
        .srst_i            (srst_i),
        .cpu_stop_n_i      (cpu_stop_n),
        .pci_link_stop_n_i (link_stop_n),
        .cfg_i             (cfg),
        .clocks_o          (clocks_o)
    );

    ////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Expected picture for the current settings and stop pins
    task automatic note(input bit cs, input bit ls);
        cso_note_t n;
        n = '{chg: '1, mask: '0, park: '0};
        if (cs)
        begin
            n.chg.cpu_clk_true  = ~cfg.cpu_en;
            n.chg.cpu_clk_comp  = ~cfg.cpu_en;
            n.mask.cpu_clk_true = cfg.cpu_en;
            n.mask.cpu_clk_comp = cfg.cpu_en;
            n.park.cpu_clk_true = cfg.cpu_en;  // Comp parks low
        end
        if (ls)
        begin
            n.chg.link_ref_clk_true  = ~cfg.src_en;
            n.chg.link_ref_clk_comp  = ~cfg.src_en;
            n.mask.link_ref_clk_true = cfg.src_en;
            n.mask.link_ref_clk_comp = cfg.src_en;
            n.park.link_ref_clk_true = cfg.src_en;
            n.chg.pci_free_clk       = ~cfg.pci_free_clk_en;
            n.mask.pci_free_clk      = cfg.pci_free_clk_en;
            n.chg.pci_clk            = '0;  // Always stoppable, park low
            n.mask.pci_clk           = '1;
        end
        q.push_back(n);
        -> go;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Watcher: four edges of activity per note; the window must cover
    // a whole PCI period so a running PCI bit is seen to change
    initial
    begin : watch
        cso_pkg::cso_clk_out_t s;
        cso_pkg::cso_clk_out_t c;
        cso_note_t             n;
        logic [17:0]           pc;   // Complement legs seen
        logic [17:0]           pt;   // Inverted true legs
        forever
        begin
            @(go);
            s = clocks_o;
            c = '0;
            repeat (4)
            begin
                @(posedge clk_i);
                #1;
                c = c | (s ^ clocks_o);
                s = clocks_o;
            end
            n = q.pop_front();
            check(c, n.chg);
            check(s & n.mask, n.park);
            pc = {12'h000, s.cpu_clk_comp, s.link_ref_clk_comp};
            pt = {12'h000, ~s.cpu_clk_true, ~s.link_ref_clk_true};
            check(pc, pt);
        end
    end

    // High pulses of a PCI clock stay two cycles, also around a stop
    always @(posedge clk_i)
    begin
        #1;
        if (srst_i)
            hi_cnt = 0;
        else if (clocks_o.pci_clk[0] === 1'b1)
            hi_cnt++;
        else if (hi_cnt != 0)
        begin
            if (seen_fall)
                check(18'(hi_cnt), 18'h0_0002);
            seen_fall = 1;
            hi_cnt    = 0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence: CPU stop, link stop, both, and a short glitch
    initial
    begin : main
        int mode;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            mode = i % 4;
            @(negedge clk_i);
            cfg <= 8'($random(seed));        // Pins high while it changes
            lag <= (mode == 3) ? 2'h0 : 2'($random(seed));
            repeat (8) @(negedge clk_i);
            if (mode == 3)
            begin
                cpu_req  <= 1'b1;            // One-cycle pin pulse
                link_req <= 1'b1;
                @(negedge clk_i);
                cpu_req  <= 1'b0;
                link_req <= 1'b0;
                repeat (14) @(negedge clk_i);
                note(0, 0);
            end
            else
            begin
                cpu_req  <= (mode != 1);
                link_req <= (mode != 0);
                repeat (16) @(negedge clk_i);
                note(cpu_req, link_req);
                repeat (6) @(negedge clk_i);
                cpu_req  <= 1'b0;
                link_req <= 1'b0;
                repeat (11) @(negedge clk_i);
                note(0, 0);
            end
            repeat (6) @(negedge clk_i);
        end
        summarize;
    end

    // Watchdog well past the expected run of some 350 cycles
    initial
    begin
        repeat (3000) @(posedge clk_i);
        bad_count++;
        summarize;
    end
endmodule // tb_top
